// File: logic/wdt_map.vh
// Register offsets, field positions, codes and timing of the watchdog
`ifndef WDT_MAP_VH
`define WDT_MAP_VH

// ========================================
// Register byte offsets
`define WDT_OFS_CTRL 8'h00
`define WDT_OFS_CODE 8'h04
`define WDT_OFS_STAT 8'h08
`define WDT_OFS_MASK 8'h0c
`define WDT_OFS_STATE 8'h10

// ========================================
// Control register fields
`define WDT_CTRL_TMO_LO 0
`define WDT_CTRL_TMO_HI 1
`define WDT_CTRL_SEL_BIT 2
`define WDT_CTRL_EN_BIT 3
`define WDT_CTRL_DIV_BIT 4
`define WDT_CTRL_RST_TMO 2'h0
`define WDT_CTRL_RST_SEL 1'b1
`define WDT_CTRL_RST_EN 1'b1
`define WDT_CTRL_RST_DIV 1'b0

// ========================================
// Status and mask fields
`define WDT_EV_W 3
`define WDT_EV_OVF 0
`define WDT_EV_SVC 1
`define WDT_EV_DIS 2

// ========================================
// State register fields
`define WDT_ST_CNT_LO 0
`define WDT_ST_CNT_HI 1
`define WDT_ST_DIS 2
`define WDT_ST_LOCK 3
`define WDT_ST_RSTPIN 4
`define WDT_ST_NMIPEND 5
`define WDT_ST_NMISVC 6

// ========================================
// Codes written to the code register
`define WDT_CODE_CLEAR 8'h4e
`define WDT_CODE_DISABLE 8'hb1

// ========================================
// Timing
`define WDT_TICK_BIT_MAX 22
`define WDT_RST_PULSE_CYC 5'h10
`define WDT_CNT_LAST 2'h3

`endif

// File: logic/wdt_sync2.v
// Two flip-flop synchroniser for one asynchronous level
`timescale 1ns/1ps
module wdt_sync2
(
    input wire clk,
    input wire rst_n,
    input wire din,
    output wire dout
);

reg meta_r;
reg sync_r;

// ========================================
// Two stage capture, pin idles high
always @(posedge clk or negedge rst_n)
begin
    if (!rst_n)
    begin
        meta_r <= 1'b1;
        sync_r <= 1'b1;
    end
    else
    begin
        meta_r <= din;
        sync_r <= meta_r;
    end
end

assign dout = sync_r;

endmodule // wdt_sync2

// File: logic/wdt_presc.v
// Free-running prescaler with selectable tick tap
`timescale 1ns/1ps
`include "wdt_map.vh"
module wdt_presc
#(
    parameter TICK_BIT_MAX = `WDT_TICK_BIT_MAX
)
(
    input wire clk,
    input wire rst_n,
    input wire run,
    input wire [1:0] tmo_sel,
    input wire div_sel,
    output wire tick
);

localparam W = TICK_BIT_MAX + 2;

reg [W-1:0] presc_r;
wire [W-1:0] presc_nxt;
wire [W-1:0] low_mask;
wire [W-1:0] tap_mask;
integer tap_bit;

// ========================================
// Tap bit: each timeout step is a quarter, divider option doubles
always @*
begin
    tap_bit = TICK_BIT_MAX - 2 * tmo_sel + div_sel;
end

assign low_mask = ({{(W-1){1'b0}}, 1'b1} << tap_bit) - {{(W-1){1'b0}}, 1'b1};
assign tap_mask = ({{(W-1){1'b0}}, 1'b1} << (tap_bit + 1))
                  - {{(W-1){1'b0}}, 1'b1};
assign presc_nxt = presc_r + {{(W-1){1'b0}}, 1'b1};

// ========================================
// Counting, frozen while run is low
always @(posedge clk or negedge rst_n)
begin
    if (!rst_n)
        presc_r <= {W{1'b0}};
    else if (run)
        presc_r <= presc_nxt;
end

// Rising edge of tapped bit, glitch free on selection change
assign tick = run && ((presc_r & tap_mask) == low_mask);

endmodule // wdt_presc

// File: logic/wdt_top.v
// Watchdog timer with reset or pseudo NMI response, APB registers
//
// Overview of operation
// - Overflow response selectable once after reset; reset is default.
// - Overflow can serve as periodic interrupt interval timer.
// - Enable bit is bit 3 of control, resets to one.
// - Free-running prescaler feeds two-bit counter; overflow is timeout.
// - Clear code clears only the binary counter, not the prescaler.
// - Overflow rising edge fires reset if select is one, else NMI.
// - Two-bit field picks four quarter-stepped periods; divider doubles.
// - Counting freezes in stop and idle, resumes from held value.
// - Disable code stops watchdog only while enable bit is zero.
// - Disable code before clearing enable bit leaves watchdog running.
// - Binary counter held at zero while watchdog is disabled.
// - Pseudo NMI ignores enables; waits while prior NMI in service.
// - Watchdog reset pulls open-drain reset pin low for 16 clocks.
`timescale 1ns/1ps
`include "wdt_map.vh"
module wdt_top
#(
    parameter TICK_BIT_MAX = `WDT_TICK_BIT_MAX
)
(
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output reg pslverr,
    input wire stop_mode,
    input wire idle_mode,
    input wire nmi_ack,
    input wire nmi_return_instruction,
    input wire sw_int_in_service,
    output wire watchdog_pseudo_nmi,
    output wire irq,
    input wire rst_pin_in,
    output wire rst_pin_out,
    output wire rst_pin_oe_n
);

// ========================================
// Declarations
reg [1:0] timeout_period_field_r;
reg overflow_response_select_r;
reg watchdog_enable_bit_r;
reg divider_stage_select_r;
reg sel_locked_r;
reg disabled_r;
reg [1:0] cnt_r;
reg [1:0] cnt_nxt;
reg [`WDT_EV_W-1:0] stat_r;
reg [`WDT_EV_W-1:0] mask_r;
reg nmi_pend_r;
reg nmi_svc_r;
reg [4:0] rst_cnt_r;
reg [31:0] rdata_nxt;
reg rd_err_nxt;
wire setup_ph;
wire wr_en;
wire wr_ctrl;
wire wr_code;
wire wr_stat;
wire wr_mask;
wire code_clear;
wire code_disable;
wire run;
wire tick;
wire overflow;
wire [`WDT_EV_W-1:0] ev_set;
wire rst_pin_sync;
wire [7:0] code_byte;

// ========================================
// APB decode, slave always ready
assign pready = 1'b1;
assign setup_ph = psel && !penable;
assign wr_en = psel && penable && pwrite;
assign wr_ctrl = wr_en && (paddr == `WDT_OFS_CTRL);
assign wr_code = wr_en && (paddr == `WDT_OFS_CODE);
assign wr_stat = wr_en && (paddr == `WDT_OFS_STAT);
assign wr_mask = wr_en && (paddr == `WDT_OFS_MASK);
assign code_byte = pwdata[7:0];

// Only the two known codes act on the watchdog
assign code_clear = wr_code && (code_byte == `WDT_CODE_CLEAR);
assign code_disable = wr_code && (code_byte == `WDT_CODE_DISABLE);

// ========================================
// Reset pin level seen back through a synchroniser
wdt_sync2 u_rst_sync
(
    .clk(pclk),
    .rst_n(presetn),
    .din(rst_pin_in),
    .dout(rst_pin_sync)
);

// ========================================
// Control register
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        timeout_period_field_r <= `WDT_CTRL_RST_TMO;
        overflow_response_select_r <= `WDT_CTRL_RST_SEL;
        watchdog_enable_bit_r <= `WDT_CTRL_RST_EN;
        divider_stage_select_r <= `WDT_CTRL_RST_DIV;
        sel_locked_r <= 1'b0;
    end
    else if (wr_ctrl)
    begin
        timeout_period_field_r <=
            pwdata[`WDT_CTRL_TMO_HI:`WDT_CTRL_TMO_LO];
        watchdog_enable_bit_r <= pwdata[`WDT_CTRL_EN_BIT];
        divider_stage_select_r <= pwdata[`WDT_CTRL_DIV_BIT];
        // First control write makes the single selection
        if (!sel_locked_r)
            overflow_response_select_r <=
                pwdata[`WDT_CTRL_SEL_BIT];
        sel_locked_r <= 1'b1;
    end
end

// ========================================
// Disabled state: needs enable bit already clear at code write
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
        disabled_r <= 1'b0;
    else if (wr_ctrl && pwdata[`WDT_CTRL_EN_BIT])
        disabled_r <= 1'b0;
    else if (code_disable && !watchdog_enable_bit_r)
        disabled_r <= 1'b1;
end

// ========================================
// Prescaler, frozen in stop and idle
assign run = !stop_mode && !idle_mode;

wdt_presc
#(
    .TICK_BIT_MAX(TICK_BIT_MAX)
)
u_presc
(
    .clk(pclk),
    .rst_n(presetn),
    .run(run),
    .tmo_sel(timeout_period_field_r),
    .div_sel(divider_stage_select_r),
    .tick(tick)
);

// ========================================
// Two-stage binary counter and overflow
assign overflow = tick && !disabled_r
                  && (cnt_r == `WDT_CNT_LAST);

always @*
begin
    cnt_nxt = cnt_r;
    if (disabled_r)
        cnt_nxt = 2'h0;
    else if (code_clear)
        cnt_nxt = 2'h0;
    else if (tick)
        cnt_nxt = cnt_r + 2'h1;
end

always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
        cnt_r <= 2'h0;
    else
        cnt_r <= cnt_nxt;
end

// ========================================
// Reset pulse on the open-drain pin
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
        rst_cnt_r <= 5'h00;
    else if (overflow && overflow_response_select_r)
        rst_cnt_r <= `WDT_RST_PULSE_CYC;
    else if (rst_cnt_r != 5'h00)
        rst_cnt_r <= rst_cnt_r - 5'h01;
end

// Pin only ever pulled low; enable active low while pulling
assign rst_pin_out = 1'b0;
assign rst_pin_oe_n = (rst_cnt_r == 5'h00);

// ========================================
// Pseudo NMI request and in-service tracking
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        nmi_pend_r <= 1'b0;
        nmi_svc_r <= 1'b0;
    end
    else
    begin
        // New overflow wins over an acknowledge in the same cycle
        if (overflow && !overflow_response_select_r)
            nmi_pend_r <= 1'b1;
        else if (nmi_ack && watchdog_pseudo_nmi)
            nmi_pend_r <= 1'b0;
        if (nmi_ack && watchdog_pseudo_nmi)
            nmi_svc_r <= 1'b1;
        else if (nmi_return_instruction)
            nmi_svc_r <= 1'b0;
    end
end

// No enable register gates it, only a handler already running
assign watchdog_pseudo_nmi = nmi_pend_r && !nmi_svc_r
                             && !sw_int_in_service;

// ========================================
// Sticky status, write one to clear, set wins
assign ev_set[`WDT_EV_OVF] = overflow;
assign ev_set[`WDT_EV_SVC] = code_clear;
assign ev_set[`WDT_EV_DIS] = code_disable && !watchdog_enable_bit_r;

always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
        stat_r <= {`WDT_EV_W{1'b0}};
    else if (wr_stat)
        stat_r <= (stat_r & ~pwdata[`WDT_EV_W-1:0]) | ev_set;
    else
        stat_r <= stat_r | ev_set;
end

always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
        mask_r <= {`WDT_EV_W{1'b0}};
    else if (wr_mask)
        mask_r <= pwdata[`WDT_EV_W-1:0];
end

// Level interrupt for interval-timer use
assign irq = |(stat_r & mask_r);

// ========================================
// Read mux, captured in the setup phase
always @*
begin
    rdata_nxt = 32'h0000_0000;
    rd_err_nxt = 1'b0;
    case (paddr)
        `WDT_OFS_CTRL:
        begin
            rdata_nxt[`WDT_CTRL_TMO_HI:`WDT_CTRL_TMO_LO] =
                timeout_period_field_r;
            rdata_nxt[`WDT_CTRL_SEL_BIT] = overflow_response_select_r;
            rdata_nxt[`WDT_CTRL_EN_BIT] = watchdog_enable_bit_r;
            rdata_nxt[`WDT_CTRL_DIV_BIT] = divider_stage_select_r;
        end
        `WDT_OFS_CODE:
            rdata_nxt = 32'h0000_0000;
        `WDT_OFS_STAT:
            rdata_nxt[`WDT_EV_W-1:0] = stat_r;
        `WDT_OFS_MASK:
            rdata_nxt[`WDT_EV_W-1:0] = mask_r;
        `WDT_OFS_STATE:
        begin
            rdata_nxt[`WDT_ST_CNT_HI:`WDT_ST_CNT_LO] = cnt_r;
            rdata_nxt[`WDT_ST_DIS] = disabled_r;
            rdata_nxt[`WDT_ST_LOCK] = sel_locked_r;
            rdata_nxt[`WDT_ST_RSTPIN] = rst_pin_sync;
            rdata_nxt[`WDT_ST_NMIPEND] = nmi_pend_r;
            rdata_nxt[`WDT_ST_NMISVC] = nmi_svc_r;
        end
        default:
            rd_err_nxt = 1'b1;
    endcase
end

// ========================================
// Read data and error registers
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        prdata <= 32'h0000_0000;
        pslverr <= 1'b0;
    end
    else if (setup_ph)
    begin
        prdata <= pwrite ? 32'h0000_0000 : rdata_nxt;
        pslverr <= rd_err_nxt;
    end
    else if (!psel)
    begin
        pslverr <= 1'b0;
    end
end

endmodule // wdt_top

// File: bench/wdt_props.sv
// Concurrent checks on the watchdog block ports
`timescale 1ns/1ps
module wdt_props
(
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire [7:0] paddr,
    input wire pslverr,
    input wire stop_mode,
    input wire idle_mode,
    input wire nmi_ack,
    input wire sw_int_in_service,
    input wire watchdog_pseudo_nmi,
    input wire rst_pin_out,
    input wire rst_pin_oe_n
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ========================================
    // Reset pin, pseudo NMI and APB error relations
    chk_pulse_len: assert property ($fell(rst_pin_oe_n) |->
        (!rst_pin_oe_n)[*8] ##1 (!rst_pin_oe_n)[*8] ##1 rst_pin_oe_n)
        else $error("reset pulse length wrong");
    chk_pin_low: assert property (!rst_pin_oe_n |->
        !rst_pin_out && !watchdog_pseudo_nmi)
        else $error("reset pin not driven low");
    chk_nmi_swmask: assert property (sw_int_in_service |->
        !watchdog_pseudo_nmi) else $error("nmi during software int");
    chk_nmi_hold: assert property (watchdog_pseudo_nmi && !nmi_ack |=>
        watchdog_pseudo_nmi || sw_int_in_service)
        else $error("nmi dropped without ack");
    chk_ack_drop: assert property (watchdog_pseudo_nmi && nmi_ack |=>
        !watchdog_pseudo_nmi) else $error("nmi held after ack");
    chk_freeze_rst: assert property ((stop_mode || idle_mode) &&
        $past(stop_mode || idle_mode) |-> !$fell(rst_pin_oe_n))
        else $error("overflow while frozen");
    chk_one_resp: assert property (!($fell(rst_pin_oe_n) &&
        $rose(watchdog_pseudo_nmi))) else $error("both responses fired");
    chk_apb_err: assert property (psel && penable && paddr > 8'h10 |->
        pslverr) else $error("unmapped access not refused");
endmodule // wdt_props
bind wdt_top wdt_props u_props
(
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .paddr(paddr), .pslverr(pslverr), .stop_mode(stop_mode),
    .idle_mode(idle_mode), .nmi_ack(nmi_ack),
    .sw_int_in_service(sw_int_in_service),
    .watchdog_pseudo_nmi(watchdog_pseudo_nmi),
    .rst_pin_out(rst_pin_out), .rst_pin_oe_n(rst_pin_oe_n)
);

// File: bench/wdt_cpu_model.sv
// CPU side model: answers the pseudo NMI and pulls up the reset pin
`timescale 1ns/1ps
module wdt_cpu_model
(
    input wire pclk,
    input wire ack_en,
    input wire watchdog_pseudo_nmi,
    input wire rst_pin_out,
    input wire rst_pin_oe_n,
    output wire rst_pin_in,
    output reg nmi_ack,
    output reg nmi_return_instruction
);
    reg svc_r = 1'b0;
    // Pull-up wins while nobody sinks the pin
    assign rst_pin_in = rst_pin_oe_n ? 1'b1 : rst_pin_out;
    // Take the request, run the handler, then return
    always @(posedge pclk)
    begin
        nmi_ack <= ack_en && watchdog_pseudo_nmi && !nmi_ack;
        svc_r <= nmi_ack;
        nmi_return_instruction <= svc_r;
    end
    initial
    begin
        nmi_ack = 1'b0;
        nmi_return_instruction = 1'b0;
    end
endmodule // wdt_cpu_model

// File: bench/wdt_top_test.sv
// Self-checking bench for the watchdog block
`timescale 1ns/1ps
`include "wdt_map.vh"
`define CHK(a, b) \
    begin \
        total_checks = total_checks + 1; \
        if ((a) !== (b)) \
        begin \
            fails = fails + 1; \
            $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); \
        end \
    end
module wdt_top_test;
    reg pclk = 1'b0;
    reg presetn = 1'b0;
    reg psel = 1'b0;
    reg penable = 1'b0;
    reg pwrite = 1'b0;
    reg [7:0] paddr = 8'h00;
    reg [31:0] pwdata = 32'h0;
    reg stop_mode = 1'b0;
    reg idle_mode = 1'b0;
    reg sw_int = 1'b0;
    reg ack_en = 1'b1;
    reg oe_q = 1'b1;
    reg nmi_q = 1'b0;
    reg [31:0] rd;
    reg err;
    wire [31:0] prdata;
    wire pready, pslverr, nmi_ack, nmi_ret, nmi, irq, rst_in, rst_out, oe_n;
    integer fails = 0, total_checks = 0, falls = 0, rises = 0, n, t, d, m;
    wire ev = (oe_q && !oe_n) || (!nmi_q && nmi);
    wdt_top #(.TICK_BIT_MAX(6)) uut
    (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .stop_mode(stop_mode),
        .idle_mode(idle_mode), .nmi_ack(nmi_ack),
        .nmi_return_instruction(nmi_ret), .sw_int_in_service(sw_int),
        .watchdog_pseudo_nmi(nmi), .irq(irq), .rst_pin_in(rst_in),
        .rst_pin_out(rst_out), .rst_pin_oe_n(oe_n)
    );
    wdt_cpu_model u_cpu
    (
        .pclk(pclk), .ack_en(ack_en), .watchdog_pseudo_nmi(nmi),
        .rst_pin_out(rst_out), .rst_pin_oe_n(oe_n), .rst_pin_in(rst_in),
        .nmi_ack(nmi_ack), .nmi_return_instruction(nmi_ret)
    );
    // ========================================
    // Clock and response edge counters
    initial
    begin
        forever #12.5 pclk = ~pclk;
    end
    always @(posedge pclk)
    begin
        oe_q <= oe_n;
        nmi_q <= nmi;
        falls <= falls + (oe_q && !oe_n);
        rises <= rises + (!nmi_q && nmi);
    end
    // ========================================
    // APB transfer, read data into rd
    task apb(input [7:0] a, input w, input [31:0] dw);
    begin
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= dw;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    end
    endtask
    // Cycles until the next overflow response
    task wait_ev(input integer lim);
    begin
        @(negedge pclk);
        n = 1;
        while (!ev && n < lim)
        begin
            @(negedge pclk);
            n = n + 1;
        end
    end
    endtask
    task end_sim;
    begin
        $display("checks=%0d mismatches=%0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    end
    endtask
    // ========================================
    // Scenarios
    task t_reset;
    begin
        apb(`WDT_OFS_CTRL, 1'b0, 32'h0);
        `CHK(rd[4:0], 5'h0c)
        apb(8'h20, 1'b1, 32'hff);
        `CHK(err, 1'b1)
        $display("reset test done");
    end
    endtask
    task t_rstout;
    begin
        apb(`WDT_OFS_MASK, 1'b1, 32'h1);
        wait_ev(700);
        `CHK(n < 700, 1'b1)
        `CHK(rst_in, 1'b0)
        `CHK(irq, 1'b1)
        n = 0;
        while (oe_n === 1'b0 && n < 40)
        begin
            @(negedge pclk);
            n = n + 1;
        end
        `CHK(n, 16)
        apb(`WDT_OFS_STAT, 1'b1, 32'h1);
        apb(`WDT_OFS_STAT, 1'b0, 32'h0);
        `CHK(rd[0], 1'b0)
        `CHK(irq, 1'b0)
        $display("reset output test done");
    end
    endtask
    task t_phase;
    begin
        d = falls;
        for (m = 0; m < 4; m = m + 1)
        begin
            apb(`WDT_OFS_CODE, 1'b1, 32'h4e);
            repeat (300) @(posedge pclk);
        end
        `CHK(falls, d)
        apb(`WDT_OFS_STAT, 1'b1, 32'h7);
        apb(`WDT_OFS_CODE, 1'b1, 32'h55);
        apb(`WDT_OFS_STAT, 1'b0, 32'h0);
        `CHK(rd[1], 1'b0)
        apb(`WDT_OFS_CODE, 1'b1, 32'h4e);
        wait_ev(600);
        `CHK(n >= 380 && n <= 520, 1'b1)
        $display("service test done");
    end
    endtask
    task t_nmi;
    begin
        apb(`WDT_OFS_CTRL, 1'b1, 32'h0b);
        apb(`WDT_OFS_CTRL, 1'b0, 32'h0);
        `CHK(rd[2], 1'b0)
        m = falls;
        for (t = 0; t < 4; t = t + 1)
            for (d = 0; d < 2; d = d + 1)
            begin
                apb(`WDT_OFS_CTRL, 1'b1, 12 + 16 * d + t);
                @(negedge pclk); // Skip an overflow of the old setting
                wait_ev(2000);
                wait_ev(2000);
                `CHK(n, 1 << (9 - 2 * t + d))
            end
        `CHK(falls, m)
        ack_en <= 1'b0;
        wait_ev(50);
        repeat (20) @(negedge pclk);
        `CHK(nmi, 1'b1)
        @(posedge pclk);
        sw_int <= 1'b1;
        @(negedge pclk);
        `CHK(nmi, 1'b0)
        @(posedge pclk);
        sw_int <= 1'b0;
        ack_en <= 1'b1;
        apb(`WDT_OFS_MASK, 1'b1, 32'h0);
        @(negedge pclk);
        `CHK(irq, 1'b0)
        apb(`WDT_OFS_MASK, 1'b1, 32'h1);
        @(negedge pclk);
        `CHK(irq, 1'b1)
        $display("nmi test done");
    end
    endtask
    task t_freeze;
    begin
        for (m = 0; m < 2; m = m + 1)
        begin
            @(posedge pclk);
            stop_mode <= (m == 0);
            idle_mode <= (m == 1);
            repeat (6) @(posedge pclk);
            t = rises;
            repeat (100) @(posedge pclk);
            `CHK(rises, t)
            stop_mode <= 1'b0;
            idle_mode <= 1'b0;
            wait_ev(50);
            `CHK(n <= 16, 1'b1)
        end
        $display("freeze test done");
    end
    endtask
    task t_disable;
    begin
        apb(`WDT_OFS_CODE, 1'b1, 32'hb1);
        apb(`WDT_OFS_CTRL, 1'b1, 32'h03);
        apb(`WDT_OFS_STATE, 1'b0, 32'h0);
        `CHK(rd[2], 1'b0)
        apb(`WDT_OFS_CODE, 1'b1, 32'h4e);
        apb(`WDT_OFS_CODE, 1'b1, 32'hb1);
        apb(`WDT_OFS_STATE, 1'b0, 32'h0);
        `CHK(rd[2:0], 3'b100)
        apb(`WDT_OFS_STAT, 1'b1, 32'h7);
        t = rises;
        repeat (100) @(posedge pclk);
        `CHK(rises, t)
        apb(`WDT_OFS_STAT, 1'b0, 32'h0);
        `CHK(rd[2:0], 3'b000)
        `CHK(irq, 1'b0)
        apb(`WDT_OFS_CTRL, 1'b1, 32'h0b);
        wait_ev(50);
        `CHK(n < 50, 1'b1)
        $display("disable test done");
    end
    endtask
    // Main sequence
    initial
    begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        t_reset;
        t_rstout;
        t_phase;
        t_nmi;
        t_freeze;
        t_disable;
        end_sim;
    end
    // Watchdog on the bench itself
    initial
    begin
        repeat (30000) @(posedge pclk);
        fails = fails + 1;
        end_sim;
    end
endmodule // wdt_top_test
